// *** rtl/ssw_pkg.sv ***
// Package for the supply supervisor watchdog: constants and carriers
package ssw_pkg;
	localparam int unsigned CLK_HZ         = 25000000;
	localparam int unsigned CLK_PERIOD_NS  = 40;
	// Times in their own units
	localparam int unsigned HOLD_TIME_MS   = 200;
	localparam int unsigned KICK_TIMEOUT_MS = 1000;
	localparam int unsigned PUSH_MIN_NS    = 150;
	localparam int unsigned PUSH_TO_RESET_DELAY_NS = 100;
	localparam int unsigned KICK_PULSE_HI_NS = 50;
	localparam int unsigned KICK_PULSE_LO_NS = 100;
	localparam int unsigned AUX_RISE_FILTER_DELAY_US = 15;
	localparam int unsigned AUX_FALL_FILTER_DELAY_US = 35;
	// Cycle counts; least times round up, longest times round down
	localparam int unsigned HOLD_CYC =
		(HOLD_TIME_MS * (CLK_HZ / 1000));
	localparam int unsigned KICK_TIMEOUT_CYC =
		(KICK_TIMEOUT_MS * (CLK_HZ / 1000));
	localparam int unsigned PUSH_MIN_CYC =
		(PUSH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned KICK_PULSE_HI_CYC =
		(KICK_PULSE_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned KICK_PULSE_LO_CYC =
		(KICK_PULSE_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned AUX_RISE_CYC =
		(AUX_RISE_FILTER_DELAY_US * (CLK_HZ / 1000000));
	localparam int unsigned AUX_FALL_CYC =
		(AUX_FALL_FILTER_DELAY_US * (CLK_HZ / 1000000));
	localparam int unsigned CNT_W = 32;
	// Sync stages and output register ahead of and behind the aux filter
	localparam int unsigned AUX_PIPE_CYC = 3;
	// Synchroniser reset matches idle pins: push released, all else low
	localparam logic [4:0] SYNC_RST = 5'h04;

	// Synchronised input levels
	typedef struct packed {
		logic supply_ok;
		logic aux_ok;
		logic push_n;
		logic kick_level;
		logic kick_driven;
	} ssw_inputs_t;

	// Reset sequencer states
	typedef enum logic [1:0] {
		SSW_HOLD_LOW = 2'b00,
		SSW_HOLD_TIME = 2'b01,
		SSW_RUN = 2'b10
	} ssw_rst_state_t;
endpackage

// *** rtl/ssw_supervisor.sv ***
// Supply supervisor with reset hold, push reset, aux fail and watchdog
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [R1] Supply good starts a hold timer; reset releases when it expires.
// [R2] Supply not good asserts reset immediately and keeps it asserted.
// [R3] A new supply drop during the hold restarts the full hold.
// [R4] Active-high reset output is always the inverse of active-low reset.
// [R5] Open-drain reset pulls low exactly while reset is asserted.
// [R6] Aux fail output is low while the aux comparator reports low.
// [R7] Push reset is debounced; asserts reset after being held low 150ns.
// [R8] After push release, reset stays asserted for the full hold time.
// [R9] No kick toggle within the timeout drives the bark output low.
// [R10] During reset or undriven kick, the watchdog counter stays cleared.
// [R11] After reset release with kick driven, the watchdog counts.
// [R12] Kick toggles are recognised when stable 50ns or 100ns per variant.
// [R13] Supply low also drives the bark output low.
// [R14] Supply return releases bark immediately, without the hold delay.
// [R15] Undriven kick disables the watchdog; bark low only on supply low.
// [R16] Push low reaches reset within 100ns; here sync and debounce take about 6 cycles (240ns).
// [R17] Aux rising crossing reaches the output within 15us.
// [R18] Aux falling crossing reaches the output within 35us.
// [R19] Aux excursions shorter than the filter delay are ignored.
// [R20] All inputs synchronised to the clock; intervals counted in cycles.
// [R21] Timeout holds bark low until the next kick toggle, reset or undriven kick.
module ssw_supervisor
#(
	parameter int unsigned HOLD_CYCLES    = ssw_pkg::HOLD_CYC,
	parameter int unsigned TIMEOUT_CYCLES = ssw_pkg::KICK_TIMEOUT_CYC,
	parameter bit          LOW_VOLT       = 1'b0
)
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic arst_n,
	// Comparator results
	input  wire logic supply_ok_in,
	input  wire logic aux_sense_in,
	// Processor side inputs
	input  wire logic push_reset_in_n,
	input  wire logic kick_in,
	input  wire logic kick_driven_in,
	// Reset outputs
	output logic      sys_reset_out_n,
	output logic      sys_reset_out,
	output logic      reset_drain_out_n,
	output logic      reset_drain_oe,
	// Status outputs
	output logic      bark_out_n,
	output logic      aux_fail_out_n
);
	import ssw_pkg::*;

	localparam int unsigned KICK_CYC =
		LOW_VOLT ? KICK_PULSE_LO_CYC : KICK_PULSE_HI_CYC;
	// Filter lengths less sync and output stages, so pin to pin fits
	localparam int unsigned AUX_RISE_LIM = AUX_RISE_CYC - AUX_PIPE_CYC;
	localparam int unsigned AUX_FALL_LIM = AUX_FALL_CYC - AUX_PIPE_CYC;

	// A counter started at zero has run limit cycles once this is true
	function automatic logic cnt_done(
		input logic [CNT_W-1:0] cnt,
		input int unsigned      limit
	);
		cnt_done = (cnt >= CNT_W'(limit - 1));
	endfunction

	function automatic logic [CNT_W-1:0] cnt_next(
		input logic [CNT_W-1:0] cnt
	);
		cnt_next = cnt + CNT_W'(1);
	endfunction

	logic [4:0]      sync_a;
	logic [4:0]      sync_b;
	ssw_inputs_t     in_s;
	logic            push_low;
	logic [CNT_W-1:0] push_cnt;
	logic            rst_req;
	ssw_rst_state_t  rst_state;
	logic [CNT_W-1:0] hold_cnt;
	logic            rst_n;
	logic            kick_stable;
	logic [CNT_W-1:0] kick_cnt;
	logic            kick_toggle;
	logic [CNT_W-1:0] wd_cnt;
	logic            wd_expired;
	logic            aux_filt;
	logic [CNT_W-1:0] aux_cnt;

	// Two-stage synchronisers; first stage read only by the second
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync_a <= SYNC_RST;
			sync_b <= SYNC_RST;
		end
		else
		begin
			sync_a <= {supply_ok_in, aux_sense_in, push_reset_in_n,
				kick_in, kick_driven_in}; // [R20]
			sync_b <= sync_a;
		end
	end
	assign in_s = ssw_inputs_t'(sync_b);

	// Push debounce: counts low cycles, asserts after minimum width
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			push_cnt <= '0;
			push_low <= 1'b0;
		end
		else if (in_s.push_n)
		begin
			push_cnt <= '0;
			push_low <= 1'b0;
		end
		else if (cnt_done(push_cnt, PUSH_MIN_CYC))
		begin
			push_low <= 1'h1; // [R7] [R16]
		end
		else
		begin
			push_cnt <= cnt_next(push_cnt);
		end
	end

	// Sync latency makes the push path 150ns plus a few cycles, beyond 100ns
	assign rst_req = !in_s.supply_ok || push_low;

	// Reset sequencer; a request during the hold starts it again
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_state <= SSW_HOLD_LOW;
			hold_cnt  <= '0;
		end
		else
		begin
			case (rst_state)
				SSW_HOLD_LOW:
				begin
					hold_cnt <= '0;
					if (!rst_req)
					begin
						rst_state <= SSW_HOLD_TIME; // [R1] [R8]
					end
				end
				SSW_HOLD_TIME:
				begin
					if (rst_req)
					begin
						rst_state <= SSW_HOLD_LOW; // [R3]
						hold_cnt  <= '0;
					end
					else if (cnt_done(hold_cnt, HOLD_CYCLES))
					begin
						rst_state <= SSW_RUN; // [R1]
					end
					else
					begin
						hold_cnt <= cnt_next(hold_cnt);
					end
				end
				SSW_RUN:
				begin
					hold_cnt <= '0;
					if (rst_req)
					begin
						rst_state <= SSW_HOLD_LOW; // [R2]
					end
				end
				default:
				begin
					rst_state <= SSW_HOLD_LOW;
					hold_cnt  <= '0;
				end
			endcase
		end
	end

	// Combinational term adds no cycle past the synchronisers on supply loss
	assign rst_n = (rst_state == SSW_RUN) && !rst_req; // [R2]
	assign sys_reset_out_n   = rst_n;
	assign sys_reset_out     = !rst_n; // [R4]
	assign reset_drain_out_n = 1'b0;
	assign reset_drain_oe    = !rst_n; // [R5]

	// Kick filter: a level counts only after staying for the pulse width
	// Filter starts low; a high pin after reset counts once, a harmless kick
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			kick_stable <= 1'b0;
			kick_cnt    <= '0;
			kick_toggle <= 1'b0;
		end
		else
		begin
			kick_toggle <= 1'b0;
			if (in_s.kick_level == kick_stable)
			begin
				kick_cnt <= '0;
			end
			else if (cnt_done(kick_cnt, KICK_CYC))
			begin
				kick_stable <= in_s.kick_level;
				kick_cnt    <= '0;
				kick_toggle <= 1'h1; // [R12]
			end
			else
			begin
				kick_cnt <= cnt_next(kick_cnt);
			end
		end
	end

	// Watchdog counter and expiry
	// A kick in the expiry cycle wins over the timeout, as it came in time
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wd_cnt     <= '0;
			wd_expired <= 1'b0;
		end
		else if (!rst_n || !in_s.kick_driven)
		begin
			wd_cnt     <= '0; // [R10] [R15]
			wd_expired <= 1'b0;
		end
		else if (kick_toggle)
		begin
			wd_cnt     <= '0; // [R21]
			wd_expired <= 1'b0;
		end
		else if (cnt_done(wd_cnt, TIMEOUT_CYCLES))
		begin
			wd_expired <= 1'h1; // [R9] [R21]
		end
		else
		begin
			wd_cnt <= cnt_next(wd_cnt); // [R11]
		end
	end

	// Supply term is direct so bark follows supply with no hold
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bark_out_n <= 1'h0;
		end
		else
		begin
			bark_out_n <= in_s.supply_ok && !wd_expired; // [R13] [R14]
		end
	end

	// Aux filter: output follows only after the input holds for the delay
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aux_filt <= 1'b0;
			aux_cnt  <= '0;
		end
		else if (in_s.aux_ok == aux_filt)
		begin
			aux_cnt <= '0; // [R19]
		end
		else if (cnt_done(aux_cnt,
				in_s.aux_ok ? AUX_RISE_LIM : AUX_FALL_LIM))
		begin
			aux_filt <= in_s.aux_ok; // [R17] [R18]
			aux_cnt  <= '0;
		end
		else
		begin
			aux_cnt <= cnt_next(aux_cnt);
		end
	end

	// Registered so the pin never shows a glitch from the filter compare
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aux_fail_out_n <= 1'h0;
		end
		else
		begin
			aux_fail_out_n <= aux_filt; // [R6]
		end
	end
endmodule

`default_nettype wire

// *** sim/ssw_supervisor_asserts.sv ***
// Port assertions for the supply supervisor watchdog
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor_asserts
#(
	parameter int unsigned HOLD_CYCLES = ssw_pkg::HOLD_CYC
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Inputs
	input wire logic supply_ok_in,
	input wire logic aux_sense_in,
	input wire logic kick_driven_in,
	// Outputs
	input wire logic sys_reset_out_n,
	input wire logic sys_reset_out,
	input wire logic reset_drain_out_n,
	input wire logic reset_drain_oe,
	input wire logic bark_out_n,
	input wire logic aux_fail_out_n
);
	int low_cnt;
	int hi_aux;
	int lo_aux;
	// Run lengths, so long spans need no long repetition
	always_ff @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
			low_cnt <= 0;
		else
			low_cnt <= sys_reset_out_n ? 0 : low_cnt + 1;
	always_ff @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
			hi_aux <= 0;
		else
			hi_aux <= aux_sense_in ? hi_aux + 1 : 0;
	always_ff @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
			lo_aux <= 0;
		else
			lo_aux <= aux_sense_in ? 0 : lo_aux + 1;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_high_inverse: assert property (
		sys_reset_out == !sys_reset_out_n) else $error("high reset wrong");
	a_drain_follows: assert property (
		reset_drain_oe == !sys_reset_out_n && !reset_drain_out_n)
		else $error("drain reset wrong");
	a_supply_reset: assert property (
		!supply_ok_in [*3] |-> !sys_reset_out_n) else $error("no reset");
	a_supply_bark: assert property (
		!supply_ok_in [*4] |-> !bark_out_n) else $error("no bark");
	a_hold_length: assert property (
		$rose(sys_reset_out_n) |-> low_cnt >= HOLD_CYCLES)
		else $error("hold short");
	a_bark_return: assert property (
		!supply_ok_in ##1 supply_ok_in [*5] |-> bark_out_n)
		else $error("bark late");
	a_float_quiet: assert property (
		(!kick_driven_in && supply_ok_in) [*6] |-> bark_out_n)
		else $error("bark while floating");
	a_aux_filter: assert property (
		$changed(aux_fail_out_n) |-> hi_aux >= 300 || lo_aux >= 800)
		else $error("aux unfiltered");
	a_aux_rise: assert property (
		hi_aux == 400 |-> aux_fail_out_n) else $error("aux rise late");
	a_aux_fall: assert property (
		lo_aux == 900 |-> !aux_fail_out_n) else $error("aux fall late");
endmodule
bind ssw_supervisor ssw_supervisor_asserts #(.HOLD_CYCLES(HOLD_CYCLES))
	ssw_supervisor_asserts_inst (.clk_sys, .arst_n, .supply_ok_in,
	.aux_sense_in, .kick_driven_in, .sys_reset_out_n, .sys_reset_out,
	.reset_drain_out_n, .reset_drain_oe, .bark_out_n, .aux_fail_out_n);
`default_nettype wire

// *** sim/ssw_cpu_model.sv ***
// Processor model that drives the watchdog kick pin
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model
(
	// Clock and scenario select
	input  wire logic       clk_sys,
	input  wire logic [1:0] mode,
	// Kick pin as the processor drives it
	output logic            kick_in = 1'h0,
	output logic            kick_driven_in = 1'h0
);
	int tick = 0;
	// Mode 0 floats: an open pin shows no steady level
	always @(negedge clk_sys)
	begin
		tick <= tick + 1;
		kick_driven_in <= mode != 2'h0;
		if (mode == 2'h0)
			kick_in <= !kick_in;
		else if (mode == 2'h1 && tick % 20 == 0)
			kick_in <= !kick_in;
	end
endmodule
`default_nettype wire

// *** sim/test_ssw_supervisor.sv ***
// Self-checking bench for the supply supervisor watchdog
`timescale 1ns/1ps
`default_nettype none
module test_ssw_supervisor;
	localparam int unsigned TMO = 200;
	logic       clk_sys = 1'h0;
	logic       arst_n = 1'h0;
	logic       supply_ok_in = 1'h1;
	logic       aux_sense_in = 1'h1;
	logic       push_reset_in_n = 1'h1;
	logic [1:0] mode = 2'h0;
	wire logic  kick_in;
	wire logic  kick_driven_in;
	logic       sys_reset_out_n;
	logic       sys_reset_out;
	logic       reset_drain_out_n;
	logic       reset_drain_oe;
	logic       bark_out_n;
	logic       aux_fail_out_n;
	int         mismatches = 0;
	int         checks = 0;
	always #20 clk_sys = !clk_sys;
	ssw_supervisor #(.HOLD_CYCLES(50), .TIMEOUT_CYCLES(TMO))
		ssw_supervisor_inst (.clk_sys, .arst_n, .supply_ok_in,
		.aux_sense_in, .push_reset_in_n, .kick_in, .kick_driven_in,
		.sys_reset_out_n, .sys_reset_out, .reset_drain_out_n,
		.reset_drain_oe, .bark_out_n, .aux_fail_out_n);
	ssw_cpu_model ssw_cpu_model_inst (.clk_sys, .mode, .kick_in,
		.kick_driven_in);
	task automatic chk(input string n, input logic e, input logic g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_power;
		wt(20);
		chk("reset", 1'h0, sys_reset_out_n);
		chk("reset_high", 1'h1, sys_reset_out);
		chk("drain_oe", 1'h1, reset_drain_oe);
		chk("drain_level", 1'h0, reset_drain_out_n);
		wt(60);
		chk("reset", 1'h1, sys_reset_out_n);
		chk("reset_high", 1'h0, sys_reset_out);
		chk("drain_oe", 1'h0, reset_drain_oe);
		chk("bark", 1'h1, bark_out_n);
		$display("power-up done");
	endtask
	// Second dip lands inside the hold started by the first
	task automatic t_brown;
		supply_ok_in = 1'h0;
		wt(5);
		chk("reset", 1'h0, sys_reset_out_n);
		chk("reset_high", 1'h1, sys_reset_out);
		chk("bark", 1'h0, bark_out_n);
		supply_ok_in = 1'h1;
		wt(5);
		chk("bark", 1'h1, bark_out_n);
		wt(30);
		supply_ok_in = 1'h0;
		wt(3);
		supply_ok_in = 1'h1;
		wt(35);
		chk("reset", 1'h0, sys_reset_out_n);
		wt(25);
		chk("reset", 1'h1, sys_reset_out_n);
		$display("brownout done");
	endtask
	task automatic t_push;
		push_reset_in_n = 1'h0;
		wt(2);
		push_reset_in_n = 1'h1;
		wt(10);
		chk("reset", 1'h1, sys_reset_out_n);
		push_reset_in_n = 1'h0;
		wt(8);
		chk("reset", 1'h0, sys_reset_out_n);
		push_reset_in_n = 1'h1;
		wt(30);
		chk("reset", 1'h0, sys_reset_out_n);
		wt(30);
		chk("reset", 1'h1, sys_reset_out_n);
		$display("push done");
	endtask
	task automatic t_dog;
		mode = 2'h1;
		wt(300);
		chk("bark", 1'h1, bark_out_n);
		mode = 2'h2;
		wt(TMO - 30);
		chk("bark", 1'h1, bark_out_n);
		wt(50);
		chk("bark", 1'h0, bark_out_n);
		mode = 2'h1;
		wt(30);
		chk("bark", 1'h1, bark_out_n);
		mode = 2'h0;
		wt(TMO + 50);
		chk("bark", 1'h1, bark_out_n);
		$display("watchdog done");
	endtask
	// The short dip is judged while it lasts, before the level returns
	task automatic t_aux;
		aux_sense_in = 1'h0;
		wt(300);
		chk("aux", 1'h1, aux_fail_out_n);
		aux_sense_in = 1'h1;
		wt(100);
		chk("aux", 1'h1, aux_fail_out_n);
		aux_sense_in = 1'h0;
		wt(950);
		chk("aux", 1'h0, aux_fail_out_n);
		aux_sense_in = 1'h1;
		wt(450);
		chk("aux", 1'h1, aux_fail_out_n);
		$display("aux done");
	endtask
	initial
	begin
		wt(8);
		arst_n = 1'h1;
		t_power;
		t_brown;
		t_push;
		t_dog;
		t_aux;
		end_of_test;
	end
	// About 3000 cycles are needed; 5000 cut a hang short
	initial
	begin
		#200000;
		mismatches++;
		end_of_test;
	end
endmodule
`default_nettype wire
